// file: ffsc_pkg.sv
// Shared constants, types and helpers for the falling-edge flop family
package ffsc_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam int unsigned ADDR_W           = 4;
    localparam logic [3:0]  OFF_ENP_CTRL     = 4'h0;
    localparam logic [3:0]  OFF_CLR_CTRL     = 4'h4;
    localparam logic [3:0]  OFF_PRE_CTRL     = 4'h8;
    localparam logic [3:0]  OFF_STATUS       = 4'hC;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned DATA_BIT         = 0;
    localparam int unsigned ENP_ENABLE_BIT   = 1;
    localparam int unsigned ENP_PRESET_BIT   = 2;
    localparam int unsigned CLR_CLEAR_BIT    = 1;
    localparam int unsigned PRE_PRESET_BIT   = 1;
    localparam int unsigned STAT_ENP_BIT     = 0;
    localparam int unsigned STAT_CLR_BIT     = 1;
    localparam int unsigned STAT_PRE_BIT     = 2;
    localparam logic [2:0]  ENP_CTRL_RESET   = 3'h4;
    localparam logic [1:0]  CLR_CTRL_RESET   = 2'h2;
    localparam logic [1:0]  PRE_CTRL_RESET   = 2'h2;
    localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

    // ************************************************************
    // Set/clear timing modes
    // ************************************************************
    typedef enum logic [1:0] {
        TIMING_IMMEDIATE = 2'b00,
        TIMING_CLOCKED   = 2'b01,
        TIMING_ILLEGAL   = 2'b10
    } ffsc_timing_t;

    // ************************************************************
    // Signal carriers
    // ************************************************************
    typedef struct packed {
        logic preset_low;
        logic enable;
        logic data;
    } ffsc_enp_ctrl_t;

    typedef struct packed {
        logic clear_low;
        logic data;
    } ffsc_clr_ctrl_t;

    typedef struct packed {
        logic preset_low;
        logic data;
    } ffsc_pre_ctrl_t;

    typedef struct packed {
        logic pre_q;
        logic clr_q;
        logic enp_q;
    } ffsc_status_t;

    // Both spellings of the immediate mode name select the same behaviour
    function automatic ffsc_timing_t decode_timing(input string mode);
        if (mode == "unclocked" || mode == "unlocked") begin
            return TIMING_IMMEDIATE;
        end
        if (mode == "clocked") begin
            return TIMING_CLOCKED;
        end
        return TIMING_ILLEGAL;
    endfunction

endpackage

// file: ffsc_flop_cell.sv
// One falling-edge storage cell with optional enable and a forcing input
`timescale 1ns/1ps
module ffsc_flop_cell #(
    parameter bit HAS_ENABLE = 1'b1,
    parameter bit FORCE_VAL  = 1'b1,
    parameter bit INIT       = 1'b1,
    parameter bit IMMEDIATE  = 1'b1
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic data,
    input  wire logic enable,
    input  wire logic force_low,
    output logic      q
);

    logic load;

    assign load = enable | ~HAS_ENABLE;

    generate
        if (IMMEDIATE && (INIT != FORCE_VAL)) begin : g_equiv
            // ****************************************************
            // Equivalent arrangement: plain flop plus output override
            // ****************************************************
            // The forcing level wins combinationally, so this output is
            // not straight from a flop; the stored bit follows it.
            logic store_ff;
            always_ff @(negedge core_clk) begin
                if (!force_low) begin
                    store_ff <= FORCE_VAL;
                end else if (rst) begin
                    store_ff <= INIT;
                end else if (load) begin
                    store_ff <= data;
                end
            end
            assign q = force_low ? store_ff : FORCE_VAL;
        end else if (IMMEDIATE) begin : g_async
            // ****************************************************
            // Native cell: asynchronous force
            // ****************************************************
            logic q_ff;
            always_ff @(negedge core_clk or negedge force_low) begin
                if (!force_low) begin
                    q_ff <= FORCE_VAL;
                end else if (rst) begin
                    q_ff <= INIT;
                end else if (load) begin
                    q_ff <= data;
                end
            end
            assign q = q_ff;
        end else begin : g_sync
            // ****************************************************
            // Clocked force: acts at the next falling edge
            // ****************************************************
            logic q_ff;
            always_ff @(negedge core_clk) begin
                if (!force_low) begin
                    q_ff <= FORCE_VAL;
                end else if (rst) begin
                    q_ff <= INIT;
                end else if (load) begin
                    q_ff <= data;
                end
                // No load and no force: hold
            end
            assign q = q_ff;
        end
    endgenerate

endmodule

// file: ffsc_avmm_handshake.sv
// Avalon-MM slave handshake: one wait state, then commit
`timescale 1ns/1ps
module ffsc_avmm_handshake (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic read,
    input  wire logic write,
    output logic      waitrequest,
    output logic      capture,
    output logic      commit_write
);

    logic ack_ff;
    logic nxt_ack;
    logic active;

    assign active       = read | write;
    // First cycle of a request stalls; read data is captured there so
    // it stands at the edge where the master sees waitrequest low.
    assign waitrequest  = active & ~ack_ff;
    assign capture      = active & ~ack_ff;
    assign commit_write = write & ack_ff;
    assign nxt_ack      = active & ~ack_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
        end
    end

endmodule

// file: ffsc_top.sv
// Falling-edge flop family with register access over Avalon-MM
//
// Notes on behaviour
// - The enable-and-preset flop powers up at its power-up value, one by default.
// - With immediate timing, a low preset forces the enable-and-preset output to one at once.
// - With clocked timing, a low preset sets the enable-and-preset output to one at the next falling edge.
// - With preset high and enable low, the enable-and-preset output holds.
// - With preset high and enable high, the enable-and-preset output takes data at each falling edge.
// - Immediate timing with a non-default power-up value is built from an equivalent arrangement.
// - With immediate timing, a low clear forces the clear flop output to zero at once.
// - With clear high, the clear flop loads data on each falling edge and holds between.
// - The clear flop powers up at its power-up value, zero by default.
// - With clocked timing, a low clear zeroes the clear flop at the next falling edge.
// - With immediate timing, a low preset forces the preset flop output to one at once.
// - With preset high, the preset flop loads data on each falling edge and holds between.
// - The preset flop powers up at its power-up value, one by default.
// - With clocked timing, a low preset sets the preset flop to one at the next falling edge.
// - Each power-up value is loaded by reset at a falling clock edge, unless the force input is low at that edge.
// - Clear and preset flops default to immediate timing.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module ffsc_top #(
    parameter bit    ENP_INIT   = 1'b1,
    parameter string ENP_TIMING = "unlocked",
    parameter bit    CLR_INIT   = 1'b0,
    parameter string CLR_TIMING = "unclocked",
    parameter bit    PRE_INIT   = 1'b1,
    parameter string PRE_TIMING = "unclocked"
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic [ffsc_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    output logic                             enp_q,
    output logic                             clr_q,
    output logic                             pre_q
);

    // ************************************************************
    // Timing mode decode and elaboration checks
    // ************************************************************
    localparam ffsc_pkg::ffsc_timing_t ENP_MODE =
        ffsc_pkg::decode_timing(ENP_TIMING);
    localparam ffsc_pkg::ffsc_timing_t CLR_MODE =
        ffsc_pkg::decode_timing(CLR_TIMING);
    localparam ffsc_pkg::ffsc_timing_t PRE_MODE =
        ffsc_pkg::decode_timing(PRE_TIMING);

    generate
        if (ENP_MODE == ffsc_pkg::TIMING_ILLEGAL ||
            CLR_MODE == ffsc_pkg::TIMING_ILLEGAL ||
            PRE_MODE == ffsc_pkg::TIMING_ILLEGAL) begin : g_bad_mode
            $error("Set/clear timing must be unclocked or clocked");
        end
    endgenerate

    // ************************************************************
    // Control registers
    // ************************************************************
    ffsc_pkg::ffsc_enp_ctrl_t enp_ctrl_ff;
    ffsc_pkg::ffsc_clr_ctrl_t clr_ctrl_ff;
    ffsc_pkg::ffsc_pre_ctrl_t pre_ctrl_ff;
    ffsc_pkg::ffsc_status_t   status;
    logic                     capture;
    logic                     commit_write;
    logic                     lane0_write;
    logic [31:0]              readdata_ff;
    logic [31:0]              nxt_readdata;

    ffsc_avmm_handshake u_handshake (
        .core_clk     (core_clk),
        .rst          (rst),
        .read         (avs_read),
        .write        (avs_write),
        .waitrequest  (avs_waitrequest),
        .capture      (capture),
        .commit_write (commit_write)
    );

    // All fields live in byte lane 0; other lanes are ignored
    assign lane0_write = commit_write & avs_byteenable[0];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            enp_ctrl_ff <= ffsc_pkg::ENP_CTRL_RESET;
        end else if (lane0_write && avs_address == ffsc_pkg::OFF_ENP_CTRL) begin
            enp_ctrl_ff.data       <= avs_writedata[ffsc_pkg::DATA_BIT];
            enp_ctrl_ff.enable     <= avs_writedata[ffsc_pkg::ENP_ENABLE_BIT];
            enp_ctrl_ff.preset_low <= avs_writedata[ffsc_pkg::ENP_PRESET_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clr_ctrl_ff <= ffsc_pkg::CLR_CTRL_RESET;
        end else if (lane0_write && avs_address == ffsc_pkg::OFF_CLR_CTRL) begin
            clr_ctrl_ff.data      <= avs_writedata[ffsc_pkg::DATA_BIT];
            clr_ctrl_ff.clear_low <= avs_writedata[ffsc_pkg::CLR_CLEAR_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pre_ctrl_ff <= ffsc_pkg::PRE_CTRL_RESET;
        end else if (lane0_write && avs_address == ffsc_pkg::OFF_PRE_CTRL) begin
            pre_ctrl_ff.data       <= avs_writedata[ffsc_pkg::DATA_BIT];
            pre_ctrl_ff.preset_low <= avs_writedata[ffsc_pkg::PRE_PRESET_BIT];
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Unmapped or misaligned addresses read as zero; writes there drop
    always_comb begin
        nxt_readdata = ffsc_pkg::READ_ZERO;
        unique case (avs_address)
            ffsc_pkg::OFF_ENP_CTRL: begin
                nxt_readdata[ffsc_pkg::DATA_BIT]       = enp_ctrl_ff.data;
                nxt_readdata[ffsc_pkg::ENP_ENABLE_BIT] = enp_ctrl_ff.enable;
                nxt_readdata[ffsc_pkg::ENP_PRESET_BIT] =
                    enp_ctrl_ff.preset_low;
            end
            ffsc_pkg::OFF_CLR_CTRL: begin
                nxt_readdata[ffsc_pkg::DATA_BIT]      = clr_ctrl_ff.data;
                nxt_readdata[ffsc_pkg::CLR_CLEAR_BIT] = clr_ctrl_ff.clear_low;
            end
            ffsc_pkg::OFF_PRE_CTRL: begin
                nxt_readdata[ffsc_pkg::DATA_BIT]       = pre_ctrl_ff.data;
                nxt_readdata[ffsc_pkg::PRE_PRESET_BIT] =
                    pre_ctrl_ff.preset_low;
            end
            ffsc_pkg::OFF_STATUS: begin
                nxt_readdata[ffsc_pkg::STAT_ENP_BIT] = status.enp_q;
                nxt_readdata[ffsc_pkg::STAT_CLR_BIT] = status.clr_q;
                nxt_readdata[ffsc_pkg::STAT_PRE_BIT] = status.pre_q;
            end
            default: begin
                nxt_readdata = ffsc_pkg::READ_ZERO;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            readdata_ff <= ffsc_pkg::READ_ZERO;
        end else if (capture && avs_read) begin
            readdata_ff <= nxt_readdata;
        end
    end

    assign avs_readdata = readdata_ff;

    // ************************************************************
    // Flop instances
    // ************************************************************
    // Cells capture on the falling edge, half a cycle after a register
    // write, so a write settles before the cell samples it.
    ffsc_flop_cell #(
        .HAS_ENABLE (1'b1),
        .FORCE_VAL  (1'b1),
        .INIT       (ENP_INIT),
        .IMMEDIATE  (ENP_MODE == ffsc_pkg::TIMING_IMMEDIATE)
    ) u_enp (
        .core_clk  (core_clk),
        .rst       (rst),
        .data      (enp_ctrl_ff.data),
        .enable    (enp_ctrl_ff.enable),
        .force_low (enp_ctrl_ff.preset_low),
        .q         (status.enp_q)
    );

    ffsc_flop_cell #(
        .HAS_ENABLE (1'b0),
        .FORCE_VAL  (1'b0),
        .INIT       (CLR_INIT),
        .IMMEDIATE  (CLR_MODE == ffsc_pkg::TIMING_IMMEDIATE)
    ) u_clr (
        .core_clk  (core_clk),
        .rst       (rst),
        .data      (clr_ctrl_ff.data),
        .enable    (1'b1),
        .force_low (clr_ctrl_ff.clear_low),
        .q         (status.clr_q)
    );

    ffsc_flop_cell #(
        .HAS_ENABLE (1'b0),
        .FORCE_VAL  (1'b1),
        .INIT       (PRE_INIT),
        .IMMEDIATE  (PRE_MODE == ffsc_pkg::TIMING_IMMEDIATE)
    ) u_pre (
        .core_clk  (core_clk),
        .rst       (rst),
        .data      (pre_ctrl_ff.data),
        .enable    (1'b1),
        .force_low (pre_ctrl_ff.preset_low),
        .q         (status.pre_q)
    );

    assign enp_q = status.enp_q;
    assign clr_q = status.clr_q;
    assign pre_q = status.pre_q;

endmodule

// file: ffsc_props.sv
// Concurrent checks on the ports of the falling-edge flop family
`timescale 1ns/1ps
module ffsc_props #(
    parameter string ENP_TIMING = "unlocked",
    parameter string CLR_TIMING = "unclocked",
    parameter string PRE_TIMING = "unclocked"
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        enp_q,
    input wire logic        clr_q,
    input wire logic        pre_q
);
    // ************
    // Shadow of the control registers
    // ************
    localparam bit ENP_IMM = (ENP_TIMING != "clocked");
    localparam bit CLR_IMM = (CLR_TIMING != "clocked");
    localparam bit PRE_IMM = (PRE_TIMING != "clocked");
    ffsc_pkg::ffsc_enp_ctrl_t enp_ff;
    ffsc_pkg::ffsc_clr_ctrl_t clr_ff;
    ffsc_pkg::ffsc_pre_ctrl_t pre_ff;
    logic                     commit;
    // Every control bit sits in byte lane 0, so writes without it are lost
    assign commit = avs_write && !avs_waitrequest && avs_byteenable[0];
    always_ff @(posedge core_clk) begin
        if (rst) begin
            enp_ff <= ffsc_pkg::ENP_CTRL_RESET;
            clr_ff <= ffsc_pkg::CLR_CTRL_RESET;
            pre_ff <= ffsc_pkg::PRE_CTRL_RESET;
        end else if (commit) begin
            if (avs_address == ffsc_pkg::OFF_ENP_CTRL)
                enp_ff <= avs_writedata[2:0];
            if (avs_address == ffsc_pkg::OFF_CLR_CTRL)
                clr_ff <= avs_writedata[1:0];
            if (avs_address == ffsc_pkg::OFF_PRE_CTRL)
                pre_ff <= avs_writedata[1:0];
        end
    end
    bus_wait_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("request not answered after one wait state");
    read_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
        |-> avs_readdata == ffsc_pkg::READ_ZERO) else $error("unmapped read");
    enp_load_a: assert property (@(negedge core_clk) disable iff (rst)
        enp_ff.preset_low && enp_ff.enable ##1 enp_ff.preset_low
        |-> enp_q == $past(enp_ff.data)) else $error("enp load lost");
    enp_hold_a: assert property (@(negedge core_clk) disable iff (rst)
        enp_ff.preset_low && !enp_ff.enable ##1 enp_ff.preset_low
        |-> $stable(enp_q)) else $error("enp moved while disabled");
    enp_force_a: assert property (@(negedge core_clk) disable iff (rst)
        ENP_IMM && !enp_ff.preset_low |-> enp_q) else $error("enp not set");
    enp_clk_a: assert property (@(negedge core_clk) disable iff (rst)
        !enp_ff.preset_low |=> enp_q) else $error("enp not set at edge");
    clr_force_a: assert property (@(negedge core_clk) disable iff (rst)
        CLR_IMM && !clr_ff.clear_low |-> !clr_q) else $error("clr not zero");
    clr_load_a: assert property (@(negedge core_clk) disable iff (rst)
        clr_ff.clear_low ##1 clr_ff.clear_low
        |-> clr_q == $past(clr_ff.data)) else $error("clr load lost");
    pre_force_a: assert property (@(negedge core_clk) disable iff (rst)
        PRE_IMM && !pre_ff.preset_low |-> pre_q) else $error("pre not set");
    pre_load_a: assert property (@(negedge core_clk) disable iff (rst)
        pre_ff.preset_low ##1 pre_ff.preset_low
        |-> pre_q == $past(pre_ff.data)) else $error("pre load lost");
endmodule

// file: ffsc_avmm_master.sv
// Avalon-MM master standing in for the fabric logic that owns the flops
`timescale 1ns/1ps
module ffsc_avmm_master (
    input  wire logic        core_clk,
    input  wire logic        waitrequest,
    input  wire logic [31:0] readdata,
    output logic      [3:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable
);
    initial begin
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hf;
    end
    // Waitrequest and read data are both taken at the rising edge
    task automatic access(input logic wr, input logic [3:0] a,
                          input logic [31:0] d, input logic [3:0] be,
                          output logic [31:0] rdata);
        @(posedge core_clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= be;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule

// file: ffsc_top_tb_top.sv
// Self-checking bench for the falling-edge flop family
`timescale 1ns/1ps
module ffsc_top_tb_top;
    // ************
    // Builds: defaults, clocked forcing, immediate with flipped init
    // ************
    localparam int LIMIT = 5000;
    logic        core_clk;
    logic        rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic        avs_waitrequest;
    logic [31:0] rd_v [3];
    logic [31:0] rd_sel;
    logic [2:0]  enp_v;
    logic [2:0]  clr_v;
    logic [2:0]  pre_v;
    int          sel = 0;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cycles = 0;
    assign rd_sel = rd_v[sel];
    ffsc_avmm_master ffsc_avmm_master_i (
        .core_clk, .waitrequest(avs_waitrequest), .readdata(rd_sel),
        .address(avs_address), .read(avs_read), .write(avs_write),
        .writedata(avs_writedata), .byteenable(avs_byteenable));
    ffsc_top ffsc_top_i (
        .core_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata(rd_v[0]),
        .avs_waitrequest, .enp_q(enp_v[0]), .clr_q(clr_v[0]), .pre_q(pre_v[0]));
    ffsc_top #(.ENP_TIMING("clocked"), .CLR_INIT(1'b1),
        .CLR_TIMING("clocked"), .PRE_INIT(1'b0), .PRE_TIMING("clocked"))
    ffsc_top_clk_i (
        .core_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata(rd_v[1]),
        .avs_waitrequest(), .enp_q(enp_v[1]), .clr_q(clr_v[1]), .pre_q(pre_v[1]));
    ffsc_top #(.ENP_INIT(1'b0), .CLR_INIT(1'b1), .CLR_TIMING("unlocked"),
        .PRE_INIT(1'b0), .PRE_TIMING("unlocked"))
    ffsc_top_inv_i (
        .core_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata(rd_v[2]),
        .avs_waitrequest(), .enp_q(enp_v[2]), .clr_q(clr_v[2]), .pre_q(pre_v[2]));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic chk_q(input logic [2:0] got, input logic [2:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %0t: outputs %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %0t: read %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] be = 4'hf);
        logic [31:0] unused;
        ffsc_avmm_master_i.access(1'b1, a, d, be, unused);
    endtask
    task automatic rd_reg(input logic [3:0] a, input int s,
                          input logic [31:0] exp);
        logic [31:0] got;
        sel = s;
        ffsc_avmm_master_i.access(1'b0, a, 32'h0000_0000, 4'hf, got);
        chk_w(got, exp);
    endtask
    // Cells capture on the falling edge; look just after it
    task automatic past_fall;
        @(negedge core_clk);
        #1;
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
    endtask
    task automatic t_powerup;
        chk_q(enp_v, 3'h3);
        chk_q(clr_v, 3'h6);
        chk_q(pre_v, 3'h1);
        rd_reg(ffsc_pkg::OFF_ENP_CTRL, 0, 32'h0000_0004);
        rd_reg(ffsc_pkg::OFF_CLR_CTRL, 0, 32'h0000_0002);
        rd_reg(ffsc_pkg::OFF_PRE_CTRL, 0, 32'h0000_0002);
        // Clear and preset cells load their zero data after release
        rd_reg(ffsc_pkg::OFF_STATUS, 0, 32'h0000_0001);
        rd_reg(ffsc_pkg::OFF_STATUS, 1, 32'h0000_0001);
    endtask
    task automatic t_enp;
        wr_reg(ffsc_pkg::OFF_ENP_CTRL, 32'h0000_0007);
        past_fall();
        chk_q(enp_v, 3'h7);
        wr_reg(ffsc_pkg::OFF_ENP_CTRL, 32'h0000_0006);
        past_fall();
        chk_q(enp_v, 3'h0);
        wr_reg(ffsc_pkg::OFF_ENP_CTRL, 32'h0000_0005);
        repeat (3) past_fall();
        chk_q(enp_v, 3'h0);
        wr_reg(ffsc_pkg::OFF_ENP_CTRL, 32'h0000_0002);
        #2;
        chk_q(enp_v, 3'h5);
        past_fall();
        chk_q(enp_v, 3'h7);
        wr_reg(ffsc_pkg::OFF_ENP_CTRL, 32'h0000_0006);
        past_fall();
        chk_q(enp_v, 3'h0);
    endtask
    task automatic t_clr;
        wr_reg(ffsc_pkg::OFF_CLR_CTRL, 32'h0000_0003);
        past_fall();
        chk_q(clr_v, 3'h7);
        wr_reg(ffsc_pkg::OFF_CLR_CTRL, 32'h0000_0001);
        #2;
        chk_q(clr_v, 3'h2);
        past_fall();
        chk_q(clr_v, 3'h0);
        wr_reg(ffsc_pkg::OFF_CLR_CTRL, 32'h0000_0003);
        past_fall();
        chk_q(clr_v, 3'h7);
    endtask
    task automatic t_pre;
        wr_reg(ffsc_pkg::OFF_PRE_CTRL, 32'h0000_0002);
        past_fall();
        chk_q(pre_v, 3'h0);
        wr_reg(ffsc_pkg::OFF_PRE_CTRL, 32'h0000_0000);
        #2;
        chk_q(pre_v, 3'h5);
        past_fall();
        chk_q(pre_v, 3'h7);
        wr_reg(ffsc_pkg::OFF_PRE_CTRL, 32'h0000_0002);
        past_fall();
        chk_q(pre_v, 3'h0);
    endtask
    task automatic t_bus;
        wr_reg(ffsc_pkg::OFF_STATUS, 32'h0000_0007);
        wr_reg(4'h2, 32'h0000_0001);
        wr_reg(ffsc_pkg::OFF_PRE_CTRL, 32'h0000_0001, 4'he);
        past_fall();
        chk_q(pre_v, 3'h0);
        rd_reg(ffsc_pkg::OFF_STATUS, 2, 32'h0000_0002);
        rd_reg(4'h1, 0, 32'h0000_0000);
        rd_reg(ffsc_pkg::OFF_PRE_CTRL, 0, 32'h0000_0002);
        rd_reg(ffsc_pkg::OFF_ENP_CTRL, 1, 32'h0000_0006);
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        do_reset();
        t_powerup();
        t_enp();
        t_clr();
        t_pre();
        t_bus();
        do_reset();
        t_powerup();
        conclude();
    end
endmodule
bind ffsc_top ffsc_props #(
    .ENP_TIMING(ENP_TIMING), .CLR_TIMING(CLR_TIMING), .PRE_TIMING(PRE_TIMING)
) ffsc_props_i (
    .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .enp_q, .clr_q, .pre_q);
